/* File: logic/fpec_top.sv */
`timescale 1ns/100ps
module fpec_top #(
	parameter int WRITE_TIME_US      = fpec_pkg::FPEC_WRITE_US,      // Word program pulse
	parameter int PAGE_ERASE_TIME_US = fpec_pkg::FPEC_PAGE_ERASE_US, // Page erase pulse
	parameter int MASS_ERASE_TIME_US = fpec_pkg::FPEC_MASS_ERASE_US, // Mass erase pulse
	parameter int COMMIT_TIME_US     = fpec_pkg::FPEC_COMMIT_US      // Protection commit
) (
	input  wire logic        sys_clk_in,            // 20 MHz system clock
	input  wire logic        reset_in,              // Power-on reset, sync, high
	input  wire logic [8:0]  avs_address_in,        // Byte address
	input  wire logic        avs_read_in,           // Read request
	input  wire logic        avs_write_in,          // Write request
	input  wire logic [31:0] avs_writedata_in,      // Write data
	input  wire logic [3:0]  avs_byteenable_in,     // Byte lanes
	output logic      [31:0] avs_readdata_out,      // Read data
	output logic             avs_waitrequest_out,   // Stall
	input  wire logic [3:0]  nv_read_perm_in,       // Stored read permissions
	input  wire logic [3:0]  nv_prog_perm_in,       // Stored program permissions
	input  wire logic        data_read_req_in,      // Data read of the array
	input  wire logic [11:0] data_read_addr_in,     // Data read offset
	input  wire logic [31:0] array_rdata_in,        // Array word at data_read_addr_in
	output logic      [31:0] data_read_out,         // Gated read word
	output logic             data_read_valid_out,   // Read word valid pulse
	output logic      [11:0] array_addr_out,        // Target offset
	output logic      [31:0] array_wdata_out,       // Word to program
	output logic             array_program_out,     // Program pulse level
	output logic             array_page_erase_out,  // Page erase pulse level
	output logic             array_mass_erase_out,  // Mass erase pulse level
	output logic             nv_commit_out,         // Protection commit level
	output logic             nv_commit_prog_out,    // 1: program perms, 0: read perms
	output logic      [3:0]  nv_commit_data_out     // Permission bits being stored
);
	import fpec_pkg::*;

	// ==========================================================
	// State
	logic [FPEC_ADDR_W-1:0]   target_address, next_target_address;
	logic [31:0]              write_data, next_write_data;
	logic [3:0]               command_busy, next_command_busy;
	logic [FPEC_BLOCKS-1:0]   read_perm, next_read_perm;
	logic [FPEC_BLOCKS-1:0]   prog_perm, next_prog_perm;
	logic [7:0]               tick_reload, next_tick_reload;
	logic [1:0]               raw_status, next_raw_status;
	logic                     bus_ack, next_bus_ack;
	logic [31:0]              rdata, next_rdata;
	fpec_state_t              state, next_state;
	logic [7:0]               tick_cnt, next_tick_cnt;
	logic [FPEC_US_CNT_W-1:0] us_left, next_us_left;
	logic [31:0]              rd_word, next_rd_word;
	logic                     rd_valid, next_rd_valid;

	// Helper signals
	// Events are combinational strobes, folded into the status bits below
	logic                     bus_req;
	logic                     wr_take;
	logic [31:0]              wmask;
	logic                     tick;
	logic [1:0]               blk;
	logic [1:0]               rd_blk;
	logic                     access_evt;
	logic                     done_evt;

	// ==========================================================
	// Bus handshake: one wait cycle, then the answer
	// Every access pays that wait cycle; it buys a registered read path
	assign bus_req             = avs_read_in | avs_write_in;
	assign avs_waitrequest_out = bus_req & ~bus_ack;
	assign wr_take             = avs_write_in & bus_ack;
	assign wmask               = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
	                              {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
	// Block index of the target and of the data read; both use the same bits
	assign blk                 = target_address[FPEC_BLK_LSB +: 2];
	assign rd_blk              = data_read_addr_in[FPEC_BLK_LSB +: 2];
	assign tick                = (state == FPEC_BUSY) && (tick_cnt == 8'h00);

	// ==========================================================
	// Register file, command decode and sequencer
	always_comb begin
		next_target_address = target_address;
		next_write_data     = write_data;
		next_command_busy   = command_busy;
		next_read_perm      = read_perm;
		next_prog_perm      = prog_perm;
		next_tick_reload    = tick_reload;
		next_raw_status     = raw_status;
		next_bus_ack        = bus_req & ~bus_ack;
		next_rdata          = rdata;
		next_state          = state;
		next_tick_cnt       = tick_cnt;
		next_us_left        = us_left;
		next_rd_word        = rd_word;
		next_rd_valid       = 1'b0;
		access_evt          = 1'b0;
		done_evt            = 1'b0;

		// Read mux, sampled in the wait cycle so data stands with the answer
		// The key field is write-only and never shows; only busy bits read back
		if (avs_read_in && !bus_ack) begin
			unique case (avs_address_in)
				FPEC_OFS_TARGET_ADDR: next_rdata = {20'h00000, target_address};
				FPEC_OFS_WRITE_DATA:  next_rdata = write_data;
				FPEC_OFS_COMMAND:     next_rdata = {28'h0000000, command_busy};
				FPEC_OFS_RAW_STATUS:  next_rdata = {30'h0000000, raw_status};
				FPEC_OFS_READ_PERM:   next_rdata = {28'h0000000, read_perm};
				FPEC_OFS_PROG_PERM:   next_rdata = {28'h0000000, prog_perm};
				FPEC_OFS_USEC_RELOAD: next_rdata = {24'h000000, tick_reload};
				default:              next_rdata = 32'h00000000;
			endcase
		end

		// Register writes take effect at the answering edge
		// Permission writes AND into the register, so a bit can only fall
		// Lane 0 carries the read_perm, prog_perm, reload and clear fields, so only byteenable[0] gates them
		if (wr_take) begin
			unique case (avs_address_in)
				FPEC_OFS_TARGET_ADDR: begin
					next_target_address = FPEC_ADDR_W'((target_address & ~wmask[11:0])
					                      | (avs_writedata_in[11:0] & wmask[11:0]));
				end
				FPEC_OFS_WRITE_DATA: begin
					next_write_data = (write_data & ~wmask) | (avs_writedata_in & wmask);
				end
				FPEC_OFS_READ_PERM: begin
					if (avs_byteenable_in[0]) begin
						next_read_perm = read_perm & avs_writedata_in[3:0];
					end
				end
				FPEC_OFS_PROG_PERM: begin
					if (avs_byteenable_in[0]) begin
						next_prog_perm = prog_perm & avs_writedata_in[3:0];
					end
				end
				FPEC_OFS_USEC_RELOAD: begin
					if (avs_byteenable_in[0]) begin
						next_tick_reload = avs_writedata_in[7:0];
					end
				end
				default: begin
				end
			endcase
		end

		// Keyed command write starts one operation when idle
		// A command while busy is dropped; software must poll the busy bit first
		// Several command bits: the first in commit, mass, page, write order wins
		if (wr_take && avs_address_in == FPEC_OFS_COMMAND && avs_byteenable_in == 4'hF
		    && avs_writedata_in[31:16] == FPEC_UNLOCK_KEY && state == FPEC_IDLE) begin
			next_tick_cnt = tick_reload;
			if (avs_writedata_in[FPEC_CMD_COMMIT]) begin
				next_command_busy = 4'h8;
				next_us_left      = FPEC_US_CNT_W'(COMMIT_TIME_US);
				next_state        = FPEC_BUSY;
			end else if (avs_writedata_in[FPEC_CMD_MASS_ERASE]) begin
				// Mass erase would touch every block, so all must be programmable
				if (&prog_perm) begin
					next_command_busy = 4'h4;
					next_us_left      = FPEC_US_CNT_W'(MASS_ERASE_TIME_US);
					next_state        = FPEC_BUSY;
				end else begin
					access_evt = 1'b1;
				end
			end else if (avs_writedata_in[FPEC_CMD_PAGE_ERASE]) begin
				if (prog_perm[blk]) begin
					next_command_busy = 4'h2;
					next_us_left      = FPEC_US_CNT_W'(PAGE_ERASE_TIME_US);
					next_state        = FPEC_BUSY;
				end else begin
					access_evt = 1'b1;
				end
			end else if (avs_writedata_in[FPEC_CMD_WRITE]) begin
				if (prog_perm[blk]) begin
					next_command_busy = 4'h1;
					next_us_left      = FPEC_US_CNT_W'(WRITE_TIME_US);
					next_state        = FPEC_BUSY;
				end else begin
					access_evt = 1'b1;
				end
			end
		end

		// Pulse timing: microsecond divider and remaining-time count
		// A tick every reload+1 cycles; the divider restarts at each start
		// Commit completion leaves the done flag alone; only write and erase set it
		unique case (state)
			FPEC_IDLE: begin
			end
			FPEC_BUSY: begin
				if (tick) begin
					next_tick_cnt = tick_reload;
					if (us_left <= FPEC_US_CNT_W'(1)) begin
						next_state        = FPEC_IDLE;
						next_command_busy = 4'h0;
						done_evt          = ~command_busy[FPEC_CMD_COMMIT];
					end else begin
						next_us_left = us_left - FPEC_US_CNT_W'(1);
					end
				end else begin
					next_tick_cnt = tick_cnt - 8'h01;
				end
			end
		endcase

		// Data reads of the array, blanked where reading is not allowed
		// A blanked word keeps protected contents off the data path
		if (data_read_req_in) begin
			next_rd_valid = 1'b1;
			if (read_perm[rd_blk]) begin
				next_rd_word = array_rdata_in;
			end else begin
				next_rd_word = 32'h00000000;
				access_evt   = 1'b1;
			end
		end

		// Status flags: clear first, so an event in the same cycle wins
		if (wr_take && avs_address_in == FPEC_OFS_STATUS_CLR && avs_byteenable_in[0]) begin
			next_raw_status = raw_status & ~avs_writedata_in[1:0];
		end
		if (access_evt) begin
			next_raw_status[FPEC_ST_ACCESS] = 1'b1;
		end
		if (done_evt) begin
			next_raw_status[FPEC_ST_DONE] = 1'b1;
		end
	end

	// Registers; power-on reset reloads the committed permissions
	// Uncommitted clears are lost here, as the stored bits come back
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			target_address <= '0;
			write_data     <= 32'h00000000;
			command_busy   <= 4'h0;
			read_perm      <= nv_read_perm_in;
			prog_perm      <= nv_prog_perm_in;
			tick_reload    <= FPEC_USEC_RESET;
			raw_status     <= 2'h0;
			bus_ack        <= 1'b0;
			rdata          <= 32'h00000000;
			state          <= FPEC_IDLE;
			tick_cnt       <= 8'h00;
			us_left        <= '0;
			rd_word        <= 32'h00000000;
			rd_valid       <= 1'b0;
		end else begin
			target_address <= next_target_address;
			write_data     <= next_write_data;
			command_busy   <= next_command_busy;
			read_perm      <= next_read_perm;
			prog_perm      <= next_prog_perm;
			tick_reload    <= next_tick_reload;
			raw_status     <= next_raw_status;
			bus_ack        <= next_bus_ack;
			rdata          <= next_rdata;
			state          <= next_state;
			tick_cnt       <= next_tick_cnt;
			us_left        <= next_us_left;
			rd_word        <= next_rd_word;
			rd_valid       <= next_rd_valid;
		end
	end

	// ==========================================================
	// Outputs toward the array and the nonvolatile store
	// Pulse levels are the busy bits, so they fall on the completion edge
	// Address and data stay live: rewriting them mid-operation moves the pulse
	assign avs_readdata_out     = rdata;
	assign data_read_out        = rd_word;
	assign data_read_valid_out  = rd_valid;
	assign array_addr_out       = target_address;
	assign array_wdata_out      = write_data;
	assign array_program_out    = command_busy[FPEC_CMD_WRITE];
	assign array_page_erase_out = command_busy[FPEC_CMD_PAGE_ERASE];
	assign array_mass_erase_out = command_busy[FPEC_CMD_MASS_ERASE];
	assign nv_commit_out        = command_busy[FPEC_CMD_COMMIT];
	assign nv_commit_prog_out   = target_address[0];
	// Data follows live register so the stored value is the one being committed
	assign nv_commit_data_out   = target_address[0] ? prog_perm : read_perm;
endmodule : fpec_top

/* File: logic/fpec_pkg.sv */
package fpec_pkg;
	// ==========================================================
	// Register byte offsets on the Avalon-MM slave
	localparam logic [8:0]  FPEC_OFS_TARGET_ADDR = 9'h000;
	localparam logic [8:0]  FPEC_OFS_WRITE_DATA  = 9'h004;
	localparam logic [8:0]  FPEC_OFS_COMMAND     = 9'h008;
	localparam logic [8:0]  FPEC_OFS_RAW_STATUS  = 9'h00C;
	localparam logic [8:0]  FPEC_OFS_STATUS_CLR  = 9'h014;
	localparam logic [8:0]  FPEC_OFS_READ_PERM   = 9'h130;
	localparam logic [8:0]  FPEC_OFS_PROG_PERM   = 9'h134;
	localparam logic [8:0]  FPEC_OFS_USEC_RELOAD = 9'h140;

	// ==========================================================
	// Field layout and reset values
	localparam int          FPEC_ADDR_W          = 12;
	localparam int          FPEC_BLOCKS          = 4;
	localparam int          FPEC_BLK_LSB         = 10;
	localparam logic [15:0] FPEC_UNLOCK_KEY      = 16'hA442;
	localparam int          FPEC_CMD_WRITE       = 0;
	localparam int          FPEC_CMD_PAGE_ERASE  = 1;
	localparam int          FPEC_CMD_MASS_ERASE  = 2;
	localparam int          FPEC_CMD_COMMIT      = 3;
	localparam int          FPEC_ST_ACCESS       = 0;
	localparam int          FPEC_ST_DONE         = 1;
	localparam logic [7:0]  FPEC_USEC_RESET      = 8'h13;
	localparam logic [3:0]  FPEC_PERM_FACTORY    = 4'hF;

	// ==========================================================
	// Pulse lengths in microseconds, counted in 1 us ticks
	localparam int          FPEC_WRITE_US        = 50;
	localparam int          FPEC_PAGE_ERASE_US   = 25000;
	localparam int          FPEC_MASS_ERASE_US   = 250000;
	localparam int          FPEC_COMMIT_US       = 50;
	localparam int          FPEC_US_CNT_W        = 18;

	// Sequencer states
	typedef enum logic [0:0] {
		FPEC_IDLE,
		FPEC_BUSY
	} fpec_state_t;
endpackage : fpec_pkg

/* File: sim/fpec_checker.sv */
`timescale 1ns/100ps
// ==========
// Bus and sequencer checks
module fpec_checker (
	input wire logic        sys_clk_in,           // Clock
	input wire logic        reset_in,             // Sync reset
	input wire logic [8:0]  avs_address_in,       // Byte address
	input wire logic        avs_read_in,          // Read
	input wire logic        avs_write_in,         // Write
	input wire logic [31:0] avs_writedata_in,     // Write data
	input wire logic        avs_waitrequest_out,  // Stall
	input wire logic        data_read_req_in,     // Array read
	input wire logic        data_read_valid_out,  // Read valid
	input wire logic [11:0] array_addr_out,       // Target
	input wire logic        array_program_out,    // Program
	input wire logic        array_page_erase_out, // Page erase
	input wire logic        array_mass_erase_out, // Mass erase
	input wire logic        nv_commit_out,        // Commit
	input wire logic        nv_commit_prog_out    // Commit select
);
	logic [3:0] ops;
	logic       cmd_ans;
	// Operation levels and the answered command write that may start one
	assign ops = {nv_commit_out, array_mass_erase_out, array_page_erase_out, array_program_out};
	assign cmd_ans = avs_write_in && !avs_waitrequest_out && avs_address_in == 9'h008;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);
	sequence seq_cmd_ans;
		cmd_ans;
	endsequence
	sequence seq_op_start;
		$rose(|ops);
	endsequence
	chk_one_wait: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
		|=> !avs_waitrequest_out) else $error("bus stalled past one cycle");
	chk_first_wait: assert property ($rose(avs_read_in) || $rose(avs_write_in)
		|-> avs_waitrequest_out) else $error("bus answered without stall");
	chk_read_valid: assert property (data_read_req_in |=> data_read_valid_out)
		else $error("array read not answered");
	chk_valid_pulse: assert property (!data_read_req_in |=> !data_read_valid_out)
		else $error("array read valid without request");
	chk_start_cmd: assert property (seq_op_start |-> $past(cmd_ans))
		else $error("operation started without command write");
	chk_key_needed: assert property (seq_cmd_ans ##1 seq_op_start
		|-> $past(avs_writedata_in[31:16]) == 16'hA442) else $error("operation started without key");
	chk_one_op: assert property ($onehot0(ops)) else $error("two operations at once");
	chk_commit_sel: assert property (nv_commit_out |-> nv_commit_prog_out == array_addr_out[0])
		else $error("commit target not from address bit");
	chk_mass_len: assert property ($rose(array_mass_erase_out) |-> array_mass_erase_out[*2])
		else $error("mass erase pulse too short");
endmodule : fpec_checker

bind fpec_top fpec_checker i_fpec_checker (.*);

/* File: sim/fpec_flash_model.sv */
`timescale 1ns/100ps
// ==========
// Flash array and nonvolatile permission store
module fpec_flash_model (
	input  wire logic        sys_clk_in,  // Clock
	input  wire logic [11:0] addr_in,     // Target offset
	input  wire logic [31:0] wdata_in,    // Word to program
	input  wire logic [3:0]  ops_in,      // Commit, mass, page, program
	input  wire logic        sel_prog_in, // Commit target
	input  wire logic [3:0]  perm_in,     // Bits to store
	input  wire logic [11:0] rd_addr_in,  // Data read offset
	output logic      [31:0] rdata_out,   // Array word
	output logic      [3:0]  rd_perm_out, // Stored read bits
	output logic      [3:0]  pg_perm_out  // Stored program bits
);
	logic [31:0] mem [1024];
	logic [3:0]  prev;
	// Erased array, factory permissions; they survive any reset
	initial begin
		prev = 4'h0;
		rd_perm_out = 4'hF;
		pg_perm_out = 4'hF;
		foreach (mem[i]) mem[i] = 32'hFFFFFFFF;
	end
	assign rdata_out = mem[rd_addr_in[11:2]];
	// Act on each rising level; programming only clears bits, as real cells do
	always @(posedge sys_clk_in) begin
		prev <= ops_in;
		if (ops_in[0] && !prev[0])
			mem[addr_in[11:2]] <= mem[addr_in[11:2]] & wdata_in;
		if (ops_in[1] && !prev[1])
			for (int i = 0; i < 256; i++) mem[{addr_in[11:10], i[7:0]}] <= 32'hFFFFFFFF;
		if (ops_in[2] && !prev[2])
			foreach (mem[i]) mem[i] <= 32'hFFFFFFFF;
		if (ops_in[3] && !prev[3] && sel_prog_in)
			pg_perm_out <= perm_in;
		if (ops_in[3] && !prev[3] && !sel_prog_in)
			rd_perm_out <= perm_in;
	end
endmodule : fpec_flash_model

/* File: sim/flash_program_erase_controller_tb.sv */
`timescale 1ns/100ps
// ==========
// Register-level regression
module flash_program_erase_controller_tb;
	logic        sys_clk_in, reset_in, avs_read_in, avs_write_in, avs_waitrequest_out;
	logic        data_read_req_in, data_read_valid_out, array_program_out, nv_commit_prog_out;
	logic        array_page_erase_out, array_mass_erase_out, nv_commit_out;
	logic [8:0]  avs_address_in;
	logic [31:0] avs_writedata_in, avs_readdata_out, array_rdata_in, data_read_out, array_wdata_out;
	logic [31:0] q;
	logic [3:0]  avs_byteenable_in, nv_read_perm_in, nv_prog_perm_in, nv_commit_data_out;
	logic [11:0] data_read_addr_in, array_addr_out;
	int          fails, n_tests, plen;
	// Short pulses keep the run brief
	fpec_top #(.WRITE_TIME_US(3), .PAGE_ERASE_TIME_US(5), .MASS_ERASE_TIME_US(7),
		.COMMIT_TIME_US(4)) i_fpec_top (.*);
	fpec_flash_model i_fpec_flash_model (.sys_clk_in(sys_clk_in), .addr_in(array_addr_out),
		.wdata_in(array_wdata_out), .ops_in({nv_commit_out, array_mass_erase_out,
		array_page_erase_out, array_program_out}), .sel_prog_in(nv_commit_prog_out),
		.perm_in(nv_commit_data_out), .rd_addr_in(data_read_addr_in), .rdata_out(array_rdata_in),
		.rd_perm_out(nv_read_perm_in), .pg_perm_out(nv_prog_perm_in));
	initial begin
		sys_clk_in = 0;
		forever #25 sys_clk_in = ~sys_clk_in;
	end
	// Program pulse length in cycles
	always @(posedge sys_clk_in) if (array_program_out) plen <= plen + 1;
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("FAIL %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report
	// One bus cycle; stall and read data are taken at the rising edge only
	task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk_in);
		avs_read_in <= !w;
		avs_write_in <= w;
		avs_address_in <= a;
		avs_writedata_in <= d;
		do begin
			@(posedge sys_clk_in);
			n++;
			if (n > 20) begin
				fails++;
				$display("FAIL %0t bus hang", $time);
				final_report();
			end
		end while (avs_waitrequest_out !== 1'b0);
		q = avs_readdata_out;
		avs_read_in <= 0;
		avs_write_in <= 0;
	endtask : bus
	task automatic rd(input logic [8:0] a, input logic [31:0] e);
		bus(0, a, 0);
		chk(q, e);
	endtask : rd
	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		bus(1, a, d);
	endtask : wr
	// Poll the command until idle, bounded
	task automatic poll();
		int n;
		n = 0;
		do begin
			bus(0, 9'h008, 0);
			n++;
		end while (q[3:0] !== 4'h0 && n < 200);
		chk(n < 200, 1);
	endtask : poll
	// One-cycle array read; valid and word are taken at the edge that ends the answer
	task automatic aread(input logic [11:0] a, input logic [31:0] e);
		@(posedge sys_clk_in);
		data_read_req_in <= 1;
		data_read_addr_in <= a;
		@(posedge sys_clk_in);
		data_read_req_in <= 0;
		@(posedge sys_clk_in);
		chk(data_read_valid_out, 1);
		chk(data_read_out, e);
	endtask : aread
	// Reset rises at the current edge and is sampled on the next six
	task automatic do_reset();
		reset_in <= 1;
		repeat (6) @(posedge sys_clk_in);
		reset_in <= 0;
	endtask : do_reset
	initial begin
		repeat (20000) @(posedge sys_clk_in);
		fails++;
		$display("FAIL %0t timeout", $time);
		final_report();
	end
	initial begin
		{fails, n_tests, plen} = 0;
		{avs_read_in, avs_write_in, data_read_req_in} = 0;
		{avs_address_in, avs_writedata_in, data_read_addr_in} = 0;
		avs_byteenable_in = 4'hF;
		do_reset();
		rd(9'h140, 32'h13);
		rd(9'h130, 32'hF);
		rd(9'h134, 32'hF);
		rd(9'h000, 32'h0);
		rd(9'h1FC, 32'h0);
		$display("test reset values done");
		wr(9'h140, 32'h1);
		wr(9'h004, 32'h12345678);
		wr(9'h000, 32'hFFFFF010);
		rd(9'h000, 32'h010);
		wr(9'h008, 32'h00000001);
		rd(9'h008, 32'h0);
		avs_byteenable_in <= 4'h1;
		wr(9'h008, 32'hA4420001);
		avs_byteenable_in <= 4'hF;
		rd(9'h008, 32'h0);
		plen = 0;
		wr(9'h008, 32'hA4420001);
		rd(9'h008, 32'h1);
		poll();
		chk(plen >= 5 && plen <= 7, 1);
		rd(9'h00C, 32'h2);
		aread(12'h010, 32'h12345678);
		wr(9'h014, 32'h3);
		rd(9'h00C, 32'h0);
		wr(9'h000, 32'h404);
		wr(9'h004, 32'h0);
		wr(9'h008, 32'hA4420001);
		poll();
		wr(9'h008, 32'hA4420002);
		rd(9'h008, 32'h2);
		wr(9'h008, 32'hA4420001);
		rd(9'h008, 32'h2);
		poll();
		aread(12'h404, 32'hFFFFFFFF);
		aread(12'h010, 32'h12345678);
		wr(9'h008, 32'hA4420004);
		rd(9'h008, 32'h4);
		poll();
		aread(12'h010, 32'hFFFFFFFF);
		rd(9'h00C, 32'h2);
		$display("test operations done");
		wr(9'h134, 32'hD);
		wr(9'h134, 32'hF);
		rd(9'h134, 32'hD);
		wr(9'h008, 32'hA4420001);
		rd(9'h008, 32'h0);
		rd(9'h00C, 32'h3);
		wr(9'h008, 32'hA4420004);
		rd(9'h008, 32'h0);
		wr(9'h130, 32'hB);
		rd(9'h130, 32'hB);
		aread(12'h800, 32'h0);
		aread(12'h404, 32'hFFFFFFFF);
		wr(9'h000, 32'h1);
		wr(9'h008, 32'hA4420008);
		rd(9'h008, 32'h8);
		poll();
		do_reset();
		rd(9'h134, 32'hD);
		rd(9'h130, 32'hF);
		rd(9'h140, 32'h13);
		$display("test protection done");
		final_report();
	end
endmodule : flash_program_erase_controller_tb
